// File: bench/uhse_status_tb.sv
// self-checking bench for the host status and event register
`timescale 1ns/100ps
`default_nettype none
module uhse_status_tb;
   logic clock_i = 0, srst_i = 1, wr_en_i = 0, run_control_i = 0, async_sched_enable_i = 0;
   logic periodic_sched_enable_i = 0, async_advance_doorbell_i = 0, async_engine_running_i = 0;
   logic periodic_engine_running_i = 0, reclamation_i = 0, engine_idle_i = 1, async_advance_i = 0;
   logic engine_error_i = 0, td_retire_i = 0, td_ioc_i = 0, td_error_i = 0, short_packet_i = 0;
   logic parity_error_i = 0, master_abort_i = 0, target_abort_i = 0, port_change_i = 0;
   logic force_resume_i = 0, wake_load_i = 0, port_change_summary_i = 0;
   logic run_clear_o, halted_o, async_sched_state_o, periodic_sched_state_o, irq_o;
   logic [31:0] wr_data_i = 32'h0, rd_data_o;
   logic [1:0] frame_list_size_i = 2'h0;
   logic [5:0] int_enable_i = 6'h00, event_flags_o;
   logic [uhse_pkg::FRAME_INDEX_WIDTH-1:0] frame_index_i = '0;
   int error_cnt = 0, n_compared = 0;
   uhse_status DUT (.*);
   always #4 clock_i = ~clock_i;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic wr(input logic [31:0] d);
      wr_data_i = d;
      wr_en_i = 1;
      cyc(1);
      wr_en_i = 0;
      cyc(2);
   endtask
   // one-cycle pulse, then settle before looking
   task automatic pl(ref logic s);
      s = 1;
      cyc(1);
      s = 0;
      cyc(2);
   endtask
   task automatic t_state;
      chk(rd_data_o, 32'h00001000);
      async_sched_enable_i = 1;
      cyc(3);
      chk(rd_data_o, 32'h00001000);
      async_engine_running_i = 1;
      reclamation_i = 1;
      cyc(2);
      chk(rd_data_o, 32'h0000b000);
      chk(async_sched_state_o, 1'b1);
      async_engine_running_i = 0;
      reclamation_i = 0;
      periodic_engine_running_i = 1;
      cyc(2);
      chk(rd_data_o, 32'h00005000);
      chk(periodic_sched_state_o, 1'b1);
      periodic_engine_running_i = 0;
      wr(32'hffffffff);
      chk(rd_data_o, 32'h00001000);
      $display("t_state done");
   endtask
   task automatic t_halt;
      run_control_i = 1;
      engine_idle_i = 0;
      cyc(3);
      chk(halted_o, 1'b0);
      run_control_i = 0;
      cyc(3);
      chk(halted_o, 1'b0);
      engine_idle_i = 1;
      cyc(3);
      chk(rd_data_o, 32'h00001000);
      $display("t_halt done");
   endtask
   task automatic t_ev;
      run_control_i = 1;
      engine_idle_i = 0;
      td_ioc_i = 1;
      td_error_i = 1;
      pl(td_retire_i);
      chk(event_flags_o, 6'h03);
      wr(32'h1);
      chk(event_flags_o, 6'h02);
      wr(32'h2);
      td_error_i = 0;
      pl(td_retire_i);
      chk(event_flags_o, 6'h01);
      wr(32'h1);
      td_ioc_i = 0;
      pl(short_packet_i);
      chk(event_flags_o, 6'h01);
      wr(32'h1);
      pl(port_change_i);
      chk(event_flags_o, 6'h04);
      wr(32'h4);
      pl(target_abort_i);
      chk(event_flags_o, 6'h10);
      chk(run_clear_o, 1'b1);
      int_enable_i = 6'h10;
      cyc(2);
      chk(irq_o, 1'b1);
      int_enable_i = 6'h2f;
      cyc(2);
      chk(irq_o, 1'b0);
      wr(32'h0);
      chk(event_flags_o, 6'h10);
      wr(32'h10);
      pl(async_advance_doorbell_i);
      pl(async_advance_i);
      chk(event_flags_o, 6'h20);
      wr(32'h20);
      frame_list_size_i = uhse_pkg::FLS_512;
      frame_index_i = 14'h1000;
      cyc(3);
      chk(event_flags_o, 6'h08);
      wr(32'h8);
      frame_index_i = 14'h0000;
      cyc(3);
      chk(event_flags_o, 6'h08);
      wr(32'h8);
      frame_list_size_i = uhse_pkg::FLS_1024;
      frame_index_i = 14'h1000;
      cyc(3);
      chk(event_flags_o, 6'h00);
      frame_index_i = 14'h2000;
      cyc(3);
      chk(event_flags_o, 6'h08);
      wr(32'h8);
      chk(rd_data_o, 32'h00000000);
      $display("t_ev done");
   endtask
   task automatic t_more;
      chk(run_clear_o, 1'b1);
      run_control_i = 0;
      cyc(2);
      chk(run_clear_o, 1'b0);
      engine_idle_i = 1;
      cyc(3);
      chk(halted_o, 1'b1);
      run_control_i = 1;
      cyc(3);
      chk(halted_o, 1'b0);
      engine_idle_i = 0;
      pl(engine_error_i);
      chk(run_clear_o, 1'b1);
      chk(event_flags_o, 6'h00);
      run_control_i = 0;
      pl(master_abort_i);
      chk(event_flags_o, 6'h10);
      wr(32'h10);
      pl(parity_error_i);
      chk(event_flags_o, 6'h10);
      wr(32'h10);
      pl(force_resume_i);
      chk(event_flags_o, 6'h04);
      wr(32'h4);
      port_change_summary_i = 1;
      pl(wake_load_i);
      chk(event_flags_o, 6'h04);
      port_change_summary_i = 0;
      pl(wake_load_i);
      chk(event_flags_o, 6'h00);
      engine_idle_i = 1;
      pl(port_change_i);
      srst_i = 1;
      cyc(2);
      srst_i = 0;
      cyc(2);
      chk(rd_data_o, 32'h00001000);
      $display("t_more done");
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      error_cnt++;
      stop_test;
   end
   initial begin
      cyc(16);
      srst_i = 0;
      cyc(2);
      t_state;
      t_halt;
      t_ev;
      t_more;
      stop_test;
   end
endmodule // uhse_status_tb
`default_nettype wire

// File: rtl/uhse_flag_bank.sv
// bank of sticky event flags, set by hardware, cleared by writing ones
`timescale 1ns/100ps
`default_nettype none
module uhse_flag_bank (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [uhse_pkg::EVENT_COUNT-1:0] set_i,
   input wire logic [uhse_pkg::EVENT_COUNT-1:0] clear_i,
   input wire logic [uhse_pkg::EVENT_COUNT-1:0] load_en_i,
   input wire logic [uhse_pkg::EVENT_COUNT-1:0] load_val_i,
   output logic [uhse_pkg::EVENT_COUNT-1:0] flags_o
);
   logic [uhse_pkg::EVENT_COUNT-1:0] flags_q;
   logic [uhse_pkg::EVENT_COUNT-1:0] flags_d;

   // a set in the same cycle as a clear or load always wins
   always_comb begin
      flags_d = ((flags_q & ~clear_i) & ~load_en_i) | (load_val_i & load_en_i) | set_i;
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         flags_q <= uhse_pkg::EVENT_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_o = flags_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   a_zero_write_keeps: assert property ((flags_q & ~clear_i & ~load_en_i) != '0 |=>
      ((flags_q & $past(flags_q & ~clear_i & ~load_en_i)) == $past(flags_q & ~clear_i & ~load_en_i)))
      else $error("flag lost without a clearing write");
   a_only_clear_drops: assert property ($fell(flags_q[0]) |-> $past(clear_i[0] | load_en_i[0]))
      else $error("flag fell without a clear");
endmodule // uhse_flag_bank
`default_nettype wire

// File: rtl/uhse_pkg.sv
// constants and types shared by the host status and event logic
package uhse_pkg;
   // status register location inside the operational register space
   localparam logic [7:0] STS_OFFSET = 8'h10;
   localparam int STS_WIDTH = 32;

   // read-only state bits
   localparam int BIT_ASYNC_STATE = 15;
   localparam int BIT_PERIODIC_STATE = 14;
   localparam int BIT_RECLAMATION = 13;
   localparam int BIT_HALTED = 12;

   // event flags, also the index into the flag bank
   localparam int EVENT_COUNT = 6;
   localparam int EV_ASYNC_ADVANCE = 5;
   localparam int EV_HOST_ERROR = 4;
   localparam int EV_ROLLOVER = 3;
   localparam int EV_PORT_CHANGE = 2;
   localparam int EV_XFER_ERROR = 1;
   localparam int EV_XFER_COMPLETE = 0;

   localparam logic [31:0] STS_READ_MASK = 32'h0000f03f;
   localparam logic [5:0] EVENT_RESET = 6'h00;
   localparam logic HALTED_RESET = 1'b1;

   // frame list size encodings and the index bit that toggles at rollover
   localparam int FRAME_INDEX_WIDTH = 14;
   localparam logic [1:0] FLS_1024 = 2'h0;
   localparam logic [1:0] FLS_512 = 2'h1;
   localparam logic [1:0] FLS_256 = 2'h2;
   localparam int ROLL_BIT_1024 = 13;
   localparam int ROLL_BIT_512 = 12;
   localparam int ROLL_BIT_256 = 11;

   typedef enum logic [2:0] {
      HALT_RUN = 3'h1,
      HALT_STOPPING = 3'h2,
      HALT_HALTED = 3'h4
   } uhse_halt_e;
endpackage : uhse_pkg

// File: rtl/uhse_rollover.sv
// frame list rollover detector following the programmed list size
`timescale 1ns/100ps
`default_nettype none
module uhse_rollover (
   input wire logic clock_i,
   input wire logic srst_i,
   input wire logic [uhse_pkg::FRAME_INDEX_WIDTH-1:0] frame_index_i,
   input wire logic [1:0] frame_list_size_i,
   output logic rollover_o
);
   logic track_q;
   logic track_d;
   logic rollover_q;
   // first cycle after reset only loads the tracker, else a high index bit
   // would look like a toggle against the cleared tracker
   logic primed_q;

   function automatic logic roll_bit(input logic [uhse_pkg::FRAME_INDEX_WIDTH-1:0] idx,
                                     input logic [1:0] frame_list_size);
      case (frame_list_size)
         uhse_pkg::FLS_512: roll_bit = idx[uhse_pkg::ROLL_BIT_512];
         uhse_pkg::FLS_256: roll_bit = idx[uhse_pkg::ROLL_BIT_256];
         default: roll_bit = idx[uhse_pkg::ROLL_BIT_1024];
      endcase
   endfunction

   // list size is only changed while halted, so a size change is not filtered
   always_comb begin
      track_d = roll_bit(frame_index_i, frame_list_size_i);
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         track_q <= 1'b0;
         rollover_q <= 1'b0;
         primed_q <= 1'b0;
      end else begin
         track_q <= track_d;
         primed_q <= 1'b1;
         rollover_q <= primed_q & (track_d ^ track_q);
      end
   end

   assign rollover_o = rollover_q;

   a_roll_on_toggle: assert property (@(posedge clock_i) disable iff (srst_i)
      !$past(srst_i) && $changed(roll_bit(frame_index_i, frame_list_size_i)) |=> rollover_o)
      else $error("rollover pulse missing on tracked bit toggle");
endmodule // uhse_rollover
`default_nettype wire

// File: rtl/uhse_status.sv
// host controller status register: schedule state, halted state, event flags
//
// Contract
// - async state bit mirrors real engine state
// - async state may lag its enable control
// - periodic state bit mirrors real engine state
// - periodic state may lag its enable control
// - read-only reclamation bit, default zero
// - halted is one at reset, zero while running
// - halted set only after engine truly stopped
// - doorbell then next async advance sets flag
// - host bus faults set host error flag
// - host error clears run control itself
// - rollover flag set when index wraps
// - rollover point follows frame list size
// - owned port change or resume sets flag
// - port flag reloads from change OR on wake
// - failed transaction sets transfer error flag
// - error with completion marker sets both flags
// - retired marked descriptor sets complete flag
// - short packet also sets complete flag
// - flags clear by writing ones; the port flag also clears on a wake reload with a zero port change summary
// - enabled set flag raises interrupt; polling works
`timescale 1ns/100ps
`default_nettype none
module uhse_status (
   input wire logic clock_i,
   input wire logic srst_i,
   // register access
   input wire logic wr_en_i,
   input wire logic [31:0] wr_data_i,
   output logic [31:0] rd_data_o,
   // command and enable controls held outside
   input wire logic run_control_i,
   input wire logic async_sched_enable_i,
   input wire logic periodic_sched_enable_i,
   input wire logic async_advance_doorbell_i,
   input wire logic [1:0] frame_list_size_i,
   input wire logic [5:0] int_enable_i,
   // schedule engine state
   input wire logic async_engine_running_i,
   input wire logic periodic_engine_running_i,
   input wire logic reclamation_i,
   input wire logic engine_idle_i,
   input wire logic async_advance_i,
   input wire logic engine_error_i,
   // transfer descriptor retirement
   input wire logic td_retire_i,
   input wire logic td_ioc_i,
   input wire logic td_error_i,
   input wire logic short_packet_i,
   // host bus faults
   input wire logic parity_error_i,
   input wire logic master_abort_i,
   input wire logic target_abort_i,
   // frame index and ports
   input wire logic [uhse_pkg::FRAME_INDEX_WIDTH-1:0] frame_index_i,
   input wire logic port_change_i,
   input wire logic force_resume_i,
   input wire logic wake_load_i,
   input wire logic port_change_summary_i,
   // outputs
   output logic run_clear_o,
   output logic halted_o,
   output logic async_sched_state_o,
   output logic periodic_sched_state_o,
   output logic [5:0] event_flags_o,
   output logic irq_o
);
   // reset image of the whole register: only the halted bit reads one
   localparam logic [31:0] STS_RESET_VALUE =
      32'(uhse_pkg::HALTED_RESET) << uhse_pkg::BIT_HALTED;

   typedef logic [uhse_pkg::EVENT_COUNT-1:0] uhse_event_t;

   // halt sequencing
   uhse_pkg::uhse_halt_e halt_state_q;
   uhse_pkg::uhse_halt_e halt_state_d;
   logic halted_q;
   logic halted_d;
   logic hw_stop_q;
   logic hw_stop_d;
   logic run_eff;
   logic fault_now;

   // schedule state mirrors
   logic async_state_q;
   logic periodic_state_q;
   logic reclamation_flag_q;

   // doorbell arming
   logic doorbell_armed_q;
   logic doorbell_armed_d;

   // event flag traffic
   logic rollover_pulse;
   uhse_event_t ev_set;
   uhse_event_t ev_clear;
   uhse_event_t ev_load_en;
   uhse_event_t ev_load_val;
   uhse_event_t flags;

   // registered outputs
   logic irq_q;
   logic [31:0] rd_data_q;

   // all three bus faults are treated alike
   function automatic logic host_fault(input logic parity,
                                       input logic m_abort,
                                       input logic t_abort);
      host_fault = parity | m_abort | t_abort;
   endfunction

   // assemble the visible register word from its parts
   function automatic logic [31:0] pack_status(input logic async_s,
                                               input logic periodic_s,
                                               input logic reclamation_flag,
                                               input logic halted,
                                               input logic [uhse_pkg::EVENT_COUNT-1:0] ev);
      logic [31:0] word;
      word = '0;
      word[uhse_pkg::BIT_ASYNC_STATE] = async_s;
      word[uhse_pkg::BIT_PERIODIC_STATE] = periodic_s;
      word[uhse_pkg::BIT_RECLAMATION] = reclamation_flag;
      word[uhse_pkg::BIT_HALTED] = halted;
      word[uhse_pkg::EVENT_COUNT-1:0] = ev;
      pack_status = word & uhse_pkg::STS_READ_MASK;
   endfunction

   always_comb begin
      fault_now = host_fault(parity_error_i, master_abort_i, target_abort_i);
   end

   // a hardware stop holds until software drops run control,
   // so a stale run bit outside cannot restart the schedule
   always_comb begin
      run_eff = run_control_i & ~hw_stop_q;
   end

   always_comb begin
      hw_stop_d = fault_now | engine_error_i | (hw_stop_q & run_control_i);
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         hw_stop_q <= 1'b0;
      end else begin
         hw_stop_q <= hw_stop_d;
      end
   end

   // stopping waits for the engine to drain its pipeline
   always_comb begin
      halt_state_d = halt_state_q;
      case (halt_state_q)
         uhse_pkg::HALT_RUN: begin
            if (!run_eff) begin
               halt_state_d = uhse_pkg::HALT_STOPPING;
            end
         end
         uhse_pkg::HALT_STOPPING: begin
            if (run_eff) begin
               halt_state_d = uhse_pkg::HALT_RUN;
            end else if (engine_idle_i) begin
               halt_state_d = uhse_pkg::HALT_HALTED;
            end
         end
         uhse_pkg::HALT_HALTED: begin
            if (run_eff) begin
               halt_state_d = uhse_pkg::HALT_RUN;
            end
         end
         default: begin
            halt_state_d = uhse_pkg::HALT_HALTED;
         end
      endcase
   end

   always_comb begin
      halted_d = (halt_state_d == uhse_pkg::HALT_HALTED);
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         halt_state_q <= uhse_pkg::HALT_HALTED;
      end else begin
         halt_state_q <= halt_state_d;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         halted_q <= uhse_pkg::HALTED_RESET;
      end else begin
         halted_q <= halted_d;
      end
   end

   // state bits follow the engines, not the enables; the lag is
   // for software to watch by comparing with its own enable bits
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         async_state_q <= 1'b0;
         periodic_state_q <= 1'b0;
      end else begin
         async_state_q <= async_engine_running_i;
         periodic_state_q <= periodic_engine_running_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         reclamation_flag_q <= 1'b0;
      end else begin
         reclamation_flag_q <= reclamation_i;
      end
   end

   // doorbell stays armed until the next asynchronous advance
   always_comb begin
      doorbell_armed_d = (doorbell_armed_q & ~async_advance_i) | async_advance_doorbell_i;
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         doorbell_armed_q <= 1'b0;
      end else begin
         doorbell_armed_q <= doorbell_armed_d;
      end
   end

   // port_change_i arrives already qualified by a cleared handoff bit
   always_comb begin
      ev_set = '0;
      ev_set[uhse_pkg::EV_XFER_COMPLETE] = (td_retire_i & td_ioc_i) | short_packet_i;
      ev_set[uhse_pkg::EV_XFER_ERROR] = td_retire_i & td_error_i;
      ev_set[uhse_pkg::EV_PORT_CHANGE] = port_change_i | force_resume_i;
      ev_set[uhse_pkg::EV_ROLLOVER] = rollover_pulse;
      ev_set[uhse_pkg::EV_HOST_ERROR] = fault_now;
      ev_set[uhse_pkg::EV_ASYNC_ADVANCE] = doorbell_armed_q & async_advance_i;
   end

   // only ones in the written word clear; reserved bits are dropped
   always_comb begin
      ev_clear = '0;
      if (wr_en_i) begin
         ev_clear = wr_data_i[uhse_pkg::EVENT_COUNT-1:0];
      end
   end

   // on wake the port flag is rebuilt from the port change summary
   always_comb begin
      ev_load_en = '0;
      ev_load_val = '0;
      ev_load_en[uhse_pkg::EV_PORT_CHANGE] = wake_load_i;
      ev_load_val[uhse_pkg::EV_PORT_CHANGE] = port_change_summary_i;
   end

   uhse_flag_bank u_flag_bank (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .set_i(ev_set),
      .clear_i(ev_clear),
      .load_en_i(ev_load_en),
      .load_val_i(ev_load_val),
      .flags_o(flags)
   );

   uhse_rollover u_rollover (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .frame_index_i(frame_index_i),
      .frame_list_size_i(frame_list_size_i),
      .rollover_o(rollover_pulse)
   );

   // disabled flags stay visible for polling, they just raise no irq
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(flags & int_enable_i);
      end
   end

   // read data trails the flags by one cycle to keep the output a flop
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         rd_data_q <= STS_RESET_VALUE;
      end else begin
         rd_data_q <= pack_status(async_state_q, periodic_state_q, reclamation_flag_q, halted_q, flags);
      end
   end

   assign rd_data_o = rd_data_q;
   assign run_clear_o = hw_stop_q;
   assign halted_o = halted_q;
   assign async_sched_state_o = async_state_q;
   assign periodic_sched_state_o = periodic_state_q;
   assign event_flags_o = flags;
   assign irq_o = irq_q;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   sequence s_host_fault;
      host_fault(parity_error_i, master_abort_i, target_abort_i);
   endsequence

   sequence s_stop_reported;
      run_clear_o && event_flags_o[uhse_pkg::EV_HOST_ERROR];
   endsequence

   sequence s_doorbell_advance;
      doorbell_armed_q && async_advance_i;
   endsequence

   a_fault_stops_run: assert property (s_host_fault |=> s_stop_reported)
      else $error("host fault did not stop run control");

   a_advance_sets_flag: assert property (
      s_doorbell_advance |=> event_flags_o[uhse_pkg::EV_ASYNC_ADVANCE])
      else $error("async advance flag missing after doorbell");

   a_halt_after_idle: assert property ($rose(halted_o) |-> $past(engine_idle_i))
      else $error("halted rose while engine busy");

   a_run_clears_halt: assert property (run_control_i && !hw_stop_q |=> !halted_o)
      else $error("halted set while running");

   a_irq_follows_flags: assert property (
      !$past(srst_i) |-> irq_o == $past(|(event_flags_o & int_enable_i)))
      else $error("interrupt does not follow enabled flags");

   a_async_mirror: assert property (
      !$past(srst_i) |-> async_sched_state_o == $past(async_engine_running_i))
      else $error("async state bit does not follow engine");
endmodule // uhse_status
`default_nettype wire
